// >>> verilog/pms_sequencer.sv
// Operation
// - sleep halts program, accepted interrupt resumes
// - direct active/subactive change keeps executing
// - active-to-active or subactive-to-subactive applies frequency
// - reset pin low enters reset state
// - no direct: standby, else sleep/subsleep by select
// - wake to active or subactive; standby to active
// - direct: active if low speed 0, else subactive
// - transition with subsleep select resets three units
// - system oscillator only in active and sleep
// - sleep halts cpu; peripherals run at active clock
// - sleep wakes on enabled unmasked interrupt only
// - reset pin low during sleep resets cpu
// - standby stops clocks, cpu and peripherals; watchdog here also runs when on internal oscillator
// - standby floats general outputs, keeps registers
// - standby interrupt restarts oscillator, waits settling
// - standby held while masked or source disabled
// - reset in standby starts oscillator; held till stable; here reset ends when the pin rises, with no settling wait
// - subactive capture timer holds, or counts subclock
// - watchdog holds unless oscillator clocked
// - subsleep timebase runs only in timekeeping function
// - subactive keeps retained peripheral registers accessible
// - active clock select 0XX undivided, 1XX by 8..64
// - subactive clock select 00 /8, 01 /4, 1X /2
// - subsleep halts all except timebase timer; watchdog here also runs when on internal oscillator
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
module pms_sequencer #(
    parameter int SETTLE_SCALE = 1  // divides settling counts for simulation
) (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic                reset_pin_n,
    input  wire logic                sleep_exec,
    input  wire logic                irq_pending,
    input  wire logic                interrupt_mask_bit,
    input  wire logic                direct_irq_enable,
    input  wire logic [3:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    output pms_pkg::pms_state_t      mode_state,
    output logic                     cpu_run,
    output logic                     cpu_reset,
    output logic                     irq_handling_start,
    output logic                     sys_osc_enable,
    output logic                     sub_osc_enable,
    output logic [2:0]               clock_divide,
    output logic                     clock_from_sub,
    output logic                     periph_clock_enable,
    output logic                     periph_unit_reset,
    output logic                     gpio_float,
    output logic                     timebase_run,
    output logic                     watchdog_run,
    output logic                     capture_run,
    output logic                     capture_on_sub,
    output logic                     periph_reg_access
);
    import pms_pkg::*;

    pms_state_t  state_r, state_nxt;
    logic [7:0]  ctrl1_r, ctrl2_r;
    logic [2:0]  periph_r;
    logic [2:0]  ma_eff_r;
    logic [1:0]  sa_eff_r;
    logic [15:0] settle_cnt_r;
    logic        res_wait_r;
    logic        ack_r;

    // settling wait lengths in system clock states, indexed by the 3-bit select
    function automatic logic [15:0] settle_lookup(input logic [2:0] sel);
        case (sel)
            3'h0:    settle_lookup = PMS_SETTLE_0;
            3'h1:    settle_lookup = PMS_SETTLE_1;
            3'h2:    settle_lookup = PMS_SETTLE_2;
            3'h3:    settle_lookup = PMS_SETTLE_3;
            3'h4:    settle_lookup = PMS_SETTLE_4;
            3'h5:    settle_lookup = PMS_SETTLE_5;
            3'h6:    settle_lookup = PMS_SETTLE_6;
            default: settle_lookup = PMS_SETTLE_7;
        endcase
    endfunction : settle_lookup

    // field decode of control registers
    wire       standby_select  = ctrl1_r[PMS_F_STANDBY_SELECT];
    wire [2:0] sts   = ctrl1_r[PMS_F_STS +: 3];
    wire       subsleep_select = ctrl2_r[PMS_F_SUBSLEEP_SELECT];
    wire       low_speed_select  = ctrl2_r[PMS_F_LOW_SPEED_SELECT];
    wire       direct_transition_enable  = ctrl2_r[PMS_F_DIRECT_TRANSITION_ENABLE];

    // a wake needs an unmasked, enabled request
    wire wake_ok     = irq_pending & ~interrupt_mask_bit;
    // direct transition falls back to sleep or subsleep when its interrupt cannot run
    wire direct_ok   = direct_transition_enable & direct_irq_enable & ~interrupt_mask_bit;
    wire wake_target_sub = low_speed_select;
    wire [15:0] settle_load = settle_lookup(sts) / 16'(SETTLE_SCALE);
    wire settle_done = (settle_cnt_r <= 16'h0001);

    // bus access: one wait cycle, then acknowledge
    wire bus_req = (avs_read | avs_write) & ~ack_r;
    wire wr_en   = avs_write & ack_r;

    // next-state decode on sleep and wake
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PMS_RESET: begin
                state_nxt = PMS_ACTIVE;
            end
            PMS_ACTIVE, PMS_SUBACTIVE: begin
                if (sleep_exec) begin
                    if (direct_ok)
                        state_nxt = low_speed_select ? PMS_SUBACTIVE : PMS_ACTIVE;
                    else if (!direct_transition_enable && standby_select)
                        state_nxt = PMS_STANDBY;
                    else
                        state_nxt = subsleep_select ? PMS_SUBSLEEP : PMS_SLEEP;
                end
            end
            PMS_SLEEP, PMS_SUBSLEEP: begin
                if (wake_ok)
                    state_nxt = wake_target_sub ? PMS_SUBACTIVE : PMS_ACTIVE;
            end
            PMS_STANDBY: begin
                if (wake_ok)
                    state_nxt = PMS_SETTLE;
            end
            PMS_SETTLE: begin
                if (settle_done)
                    state_nxt = PMS_ACTIVE;
            end
            default: state_nxt = PMS_RESET;
        endcase
    end

    // mode state; reset pin overrides any mode
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            state_r <= PMS_RESET;
        else if (!reset_pin_n)
            state_r <= PMS_RESET;
        else
            state_r <= state_nxt;
    end

    // pin-reset from standby must keep the oscillator up until release
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            res_wait_r <= 1'b0;
        else
            res_wait_r <= ~reset_pin_n;
    end

    // settling down-counter, loaded on standby wake
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            settle_cnt_r <= 16'h0000;
        else if (state_r == PMS_STANDBY)
            settle_cnt_r <= settle_load;
        else if (state_r == PMS_SETTLE && !settle_done)
            settle_cnt_r <= settle_cnt_r - 16'h0001;
    end

    // selects in force after this edge; a sleep applies the new fields at once
    // so the divider never runs a cycle on the stale ratio
    wire       sel_take   = sleep_exec && (state_r == PMS_ACTIVE || state_r == PMS_SUBACTIVE);
    wire [2:0] ma_eff_nxt = sel_take ? ctrl2_r[PMS_F_MA +: 3] : ma_eff_r;
    wire [1:0] sa_eff_nxt = sel_take ? ctrl2_r[PMS_F_SA +: 2] : sa_eff_r;

    // clock selects latch only when sleep executes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ma_eff_r <= 3'h0;
            sa_eff_r <= 2'h0;
        end else begin
            ma_eff_r <= ma_eff_nxt;
            sa_eff_r <= sa_eff_nxt;
        end
    end

    // clock divider decode
    wire [2:0] ma_div = ma_eff_nxt[2] ? 3'(PMS_DIV_8 + {1'b0, ma_eff_nxt[1:0]}) : PMS_DIV_1;
    wire [2:0] sa_div = sa_eff_nxt[1] ? PMS_DIV_2 : (sa_eff_nxt[0] ? PMS_DIV_4 : PMS_DIV_8);

    // status of next state drives the mode outputs except sub_osc_enable, which stays on
    wire n_act  = state_nxt == PMS_ACTIVE;
    wire n_slp  = state_nxt == PMS_SLEEP;
    wire n_sub  = state_nxt == PMS_SUBACTIVE;
    wire n_ssl  = state_nxt == PMS_SUBSLEEP;
    wire n_stb  = state_nxt == PMS_STANDBY;
    wire n_set  = state_nxt == PMS_SETTLE;
    wire n_rst  = (state_nxt == PMS_RESET) | ~reset_pin_n;
    wire lowpwr = n_sub | n_ssl | n_stb;
    wire leave_mode = (state_r != state_nxt) | (sleep_exec & state_nxt == state_r);
    wire wake_irq = ((state_r == PMS_SLEEP || state_r == PMS_SUBSLEEP) && wake_ok)
                  | (state_r == PMS_SETTLE && settle_done)
                  | (sleep_exec && direct_ok && (n_act || n_sub));

    // registered mode outputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cpu_run             <= 1'b0;
            cpu_reset           <= 1'b1;
            irq_handling_start  <= 1'b0;
            sys_osc_enable      <= 1'b1;
            sub_osc_enable      <= 1'b1;
            clock_divide        <= PMS_DIV_1;
            clock_from_sub      <= 1'b0;
            periph_clock_enable <= 1'b0;
            periph_unit_reset   <= 1'b1;
            gpio_float          <= 1'b0;
            timebase_run        <= 1'b0;
            watchdog_run        <= 1'b0;
            capture_run         <= 1'b0;
            capture_on_sub      <= 1'b0;
            periph_reg_access   <= 1'b0;
        end else begin
            cpu_run             <= (n_act | n_sub) & reset_pin_n;
            cpu_reset           <= n_rst;
            irq_handling_start  <= wake_irq & reset_pin_n;
            // oscillator also restarted by reset pin or settling wait
            sys_osc_enable      <= n_act | n_slp | n_set | n_rst | res_wait_r;
            sub_osc_enable      <= 1'b1;
            clock_divide        <= (n_sub | n_ssl) ? sa_div : ma_div;
            clock_from_sub      <= n_sub | n_ssl;
            periph_clock_enable <= n_act | n_slp;
            periph_unit_reset   <= n_rst | lowpwr | (leave_mode & subsleep_select);
            gpio_float          <= n_stb;
            timebase_run        <= n_act | n_slp | n_sub
                                 | (n_ssl & periph_r[PMS_F_TB_KEEP]);
            watchdog_run        <= n_act | n_slp | periph_r[PMS_F_WD_OSC];
            capture_run         <= n_act | n_slp | (n_sub & periph_r[PMS_F_CT_INT]);
            capture_on_sub      <= n_sub & periph_r[PMS_F_CT_INT];
            periph_reg_access   <= n_act | n_sub;
        end
    end

    // register file writes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl1_r  <= PMS_CTRL1_RST;
            ctrl2_r  <= PMS_CTRL2_RST;
            periph_r <= 3'h0;
        end else if (wr_en) begin
            case (avs_address)
                PMS_OFS_CTRL1:  ctrl1_r  <= avs_writedata[7:0] & PMS_CTRL1_RD_MASK;
                PMS_OFS_CTRL2:  ctrl2_r  <= avs_writedata[7:0];
                PMS_OFS_PERIPH: periph_r <= avs_writedata[2:0];
                default:        ctrl1_r  <= ctrl1_r;
            endcase
        end
    end

    // read mux; unmapped reads return zero
    wire [31:0] rd_mux =
        (avs_address == PMS_OFS_CTRL1)  ? {24'h000000, ctrl1_r} :
        (avs_address == PMS_OFS_CTRL2)  ? {24'h000000, ctrl2_r} :
        (avs_address == PMS_OFS_STATUS) ? {settle_cnt_r, 13'h0000, state_r} :
        (avs_address == PMS_OFS_PERIPH) ? {29'h0, periph_r} : 32'h00000000;

    // one-wait-state slave: waitrequest falls in the cycle after the request;
    // waitrequest has its own flop so the pin carries no gate after a register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_r           <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
            mode_state      <= PMS_RESET;
        end else begin
            ack_r           <= bus_req;
            avs_waitrequest <= ~bus_req;
            avs_readdata    <= bus_req ? rd_mux : avs_readdata;
            mode_state      <= n_rst ? PMS_RESET : state_nxt;
        end
    end
endmodule : pms_sequencer

// >>> verilog/pms_pkg.sv
package pms_pkg;
    // operating states, gray coded along active -> sleep -> wait -> subsleep
    typedef enum logic [2:0] {
        PMS_RESET     = 3'h0,
        PMS_ACTIVE    = 3'h1,
        PMS_SLEEP     = 3'h3,
        PMS_SETTLE    = 3'h2,
        PMS_SUBSLEEP  = 3'h6,
        PMS_SUBACTIVE = 3'h7,
        PMS_STANDBY   = 3'h5
    } pms_state_t;

    // register offsets (byte addresses, one word each)
    localparam logic [3:0] PMS_OFS_CTRL1  = 4'h0; // system_control_one
    localparam logic [3:0] PMS_OFS_CTRL2  = 4'h4; // system_control_two
    localparam logic [3:0] PMS_OFS_STATUS = 4'h8; // settling count and state
    localparam logic [3:0] PMS_OFS_PERIPH = 4'hC; // peripheral options

    // system_control_one fields
    localparam int PMS_F_STANDBY_SELECT  = 7;  // standby_select
    localparam int PMS_F_STS   = 4;  // settling_time_select, bits 6:4
    // system_control_two fields
    localparam int PMS_F_SUBSLEEP_SELECT = 7;  // subsleep_select
    localparam int PMS_F_LOW_SPEED_SELECT  = 6;  // low_speed_select
    localparam int PMS_F_DIRECT_TRANSITION_ENABLE  = 5;  // direct_transition_enable
    localparam int PMS_F_MA    = 2;  // active_clock_select, bits 4:2
    localparam int PMS_F_SA    = 0;  // subactive_clock_select, bits 1:0
    // peripheral option fields
    localparam int PMS_F_WD_OSC  = 0; // watchdog counts on internal oscillator
    localparam int PMS_F_TB_KEEP = 1; // timebase in timekeeping function
    localparam int PMS_F_CT_INT  = 2; // capture timer counts internal clock

    localparam logic [7:0] PMS_CTRL1_RST = 8'h00;
    localparam logic [7:0] PMS_CTRL2_RST = 8'h00;

    // settling wait lengths in system clock states, per settling_time_select code
    localparam logic [15:0] PMS_SETTLE_0 = 16'h2000;
    localparam logic [15:0] PMS_SETTLE_1 = 16'h4000;
    localparam logic [15:0] PMS_SETTLE_2 = 16'h0400;
    localparam logic [15:0] PMS_SETTLE_3 = 16'h0800;
    localparam logic [15:0] PMS_SETTLE_4 = 16'h1000;
    localparam logic [15:0] PMS_SETTLE_5 = 16'h0040;
    localparam logic [15:0] PMS_SETTLE_6 = 16'h0020;
    localparam logic [15:0] PMS_SETTLE_7 = 16'h0001;

    // divider codes driven to the clock divider (log2 of ratio)
    localparam logic [2:0] PMS_DIV_1  = 3'h0;
    localparam logic [2:0] PMS_DIV_2  = 3'h1;
    localparam logic [2:0] PMS_DIV_4  = 3'h2;
    localparam logic [2:0] PMS_DIV_8  = 3'h3;
    localparam logic [2:0] PMS_DIV_64 = 3'h6;

    localparam logic [7:0] PMS_CTRL1_RD_MASK = 8'hF0;
endpackage : pms_pkg

// >>> tb/pms_sequencer_sva.sv
`timescale 1ns/10ps
module pms_sequencer_sva
    import pms_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        reset_pin_n,
    input wire logic        sleep_exec,
    input wire logic        irq_pending,
    input wire logic        interrupt_mask_bit,
    input wire logic        direct_irq_enable,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    input wire pms_state_t  mode_state,
    input wire logic        cpu_run,
    input wire logic        cpu_reset,
    input wire logic        sys_osc_enable,
    input wire logic        sub_osc_enable,
    input wire logic        periph_clock_enable,
    input wire logic        periph_unit_reset,
    input wire logic        gpio_float,
    input wire logic        capture_run
);
    logic [7:0] sc1_r;
    logic [7:0] sc2_r;
    wire standby_select = sc1_r[PMS_F_STANDBY_SELECT];
    wire subsleep_select = sc2_r[PMS_F_SUBSLEEP_SELECT];
    wire low_speed_select = sc2_r[PMS_F_LOW_SPEED_SELECT];
    wire direct_transition_enable = sc2_r[PMS_F_DIRECT_TRANSITION_ENABLE];
    wire go = sleep_exec && reset_pin_n && mode_state == PMS_ACTIVE;
    wire halted = mode_state inside {PMS_SLEEP, PMS_SUBSLEEP, PMS_STANDBY};

    // mirror of the control bytes, taken only on accepted writes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sc1_r <= 8'h00;
            sc2_r <= 8'h00;
        end else if (avs_write && !avs_waitrequest) begin
            if (avs_address == PMS_OFS_CTRL1) sc1_r <= avs_writedata[7:0];
            if (avs_address == PMS_OFS_CTRL2) sc2_r <= avs_writedata[7:0];
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    chk_osc_halted: assert property (
        mode_state inside {PMS_SUBACTIVE, PMS_SUBSLEEP, PMS_STANDBY} |-> !sys_osc_enable)
        else $error("system oscillator on in low power state");
    chk_sub_osc: assert property (sub_osc_enable)
        else $error("subclock oscillator stopped");
    chk_pin_reset: assert property (
        !reset_pin_n |=> mode_state == PMS_RESET && cpu_reset)
        else $error("reset pin did not reset");
    chk_standby_entry: assert property (go && !direct_transition_enable && standby_select |=> mode_state == PMS_STANDBY)
        else $error("standby not entered");
    chk_sleep_entry: assert property (
        go && !direct_transition_enable && !standby_select |=> mode_state == (subsleep_select ? PMS_SUBSLEEP : PMS_SLEEP))
        else $error("sleep kind wrong");
    chk_direct_move: assert property (
        go && direct_transition_enable && direct_irq_enable && !interrupt_mask_bit && (low_speed_select || !subsleep_select)
        |=> mode_state == (low_speed_select ? PMS_SUBACTIVE : PMS_ACTIVE) && cpu_run)
        else $error("direct transition wrong");
    chk_halt_hold: assert property (
        halted && reset_pin_n && (interrupt_mask_bit || !irq_pending)
        |=> mode_state == $past(mode_state))
        else $error("halt left without enabled interrupt");
    chk_sleep_wake: assert property (
        mode_state inside {PMS_SLEEP, PMS_SUBSLEEP} && reset_pin_n && irq_pending
        && !interrupt_mask_bit |-> ##[1:4] mode_state == (low_speed_select ? PMS_SUBACTIVE : PMS_ACTIVE))
        else $error("wake state wrong");
    chk_standby_look: assert property (
        mode_state == PMS_STANDBY |-> gpio_float && !cpu_run && !periph_clock_enable)
        else $error("standby outputs wrong");
    chk_sleep_look: assert property (
        mode_state == PMS_SLEEP |-> !cpu_run && periph_clock_enable)
        else $error("sleep outputs wrong");
    chk_subsleep_units: assert property (
        mode_state == PMS_SUBSLEEP |-> periph_unit_reset && !capture_run && !cpu_run)
        else $error("subsleep units wrong");
    chk_settle_osc: assert property (mode_state == PMS_SETTLE |-> sys_osc_enable)
        else $error("oscillator off while settling");

    cover property (mode_state == PMS_SETTLE ##1 mode_state == PMS_ACTIVE);
    cover property (go ##1 mode_state == PMS_SUBACTIVE);
    cover property (mode_state == PMS_STANDBY ##1 mode_state == PMS_RESET);
endmodule : pms_sequencer_sva

bind pms_sequencer pms_sequencer_sva u_sva (.*);

// >>> tb/pms_cpu_model.sv
`timescale 1ns/10ps
module pms_cpu_model (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       cpu_run,
    input wire logic       cpu_reset,
    input wire logic       irq_handling_start,
    input wire logic       sleep_cmd,
    input wire logic       irq_cmd,
    input wire logic [1:0] lag,
    output logic           sleep_exec,
    output logic           irq_pending
);
    logic [1:0] wait_r;
    logic       armed_r;

    // a slow core stalls lag cycles; a halted core cannot issue the instruction
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            armed_r <= 1'b0;
            wait_r <= 2'h0;
            sleep_exec <= 1'b0;
        end else begin
            sleep_exec <= 1'b0;
            if (sleep_cmd) begin
                armed_r <= 1'b1;
                wait_r <= lag;
            end else if (armed_r && wait_r != 2'h0) begin
                wait_r <= wait_r - 2'h1;
            end else if (armed_r && cpu_run) begin
                armed_r <= 1'b0;
                sleep_exec <= 1'b1;
            end
        end
    end

    // request held until the handler starts or the core is reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) irq_pending <= 1'b0;
        else if (irq_cmd) irq_pending <= 1'b1;
        else if (irq_handling_start || cpu_reset) irq_pending <= 1'b0;
    end
endmodule : pms_cpu_model

// >>> tb/test_power_mode_sequencer.sv
`timescale 1ns/10ps
module test_power_mode_sequencer;
    import pms_pkg::*;
    logic clock, rst, reset_pin_n, sleep_exec, irq_pending, interrupt_mask_bit;
    logic direct_irq_enable, avs_read, avs_write, avs_waitrequest, cpu_run, cpu_reset;
    logic irq_handling_start, sys_osc_enable, sub_osc_enable, clock_from_sub, gpio_float;
    logic periph_clock_enable, periph_unit_reset, timebase_run, watchdog_run;
    logic capture_run, capture_on_sub, periph_reg_access, sleep_cmd, irq_cmd;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [2:0]  clock_divide, ma, opt, sts;
    logic [1:0]  sa, lag;
    pms_state_t  mode_state, es;
    int          fails, check_count, cycles, dt, sb, sm, ls;

    pms_sequencer #(.SETTLE_SCALE(64)) dut (.*);
    pms_cpu_model model (.clock(clock), .rst(rst), .cpu_run(cpu_run), .cpu_reset(cpu_reset),
        .irq_handling_start(irq_handling_start), .sleep_cmd(sleep_cmd), .irq_cmd(irq_cmd),
        .lag(lag), .sleep_exec(sleep_exec), .irq_pending(irq_pending));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_val

    task automatic cmp_state(input pms_state_t got, input pms_state_t exp);
        cmp_val({29'h0, got}, {29'h0, exp});
    endtask : cmp_state

    // one bus cycle, held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        // look between edges so the flop update at the edge cannot race the test
        do @(negedge clock); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        @(posedge clock);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask : bus

    // pin held low five cycles, then released; waits until the mode is active again
    task automatic pin_reset();
        reset_pin_n <= 1'b0;
        repeat (2) @(posedge clock);
        cmp_state(mode_state, PMS_RESET);
        cmp_val(sys_osc_enable, 1);
        repeat (3) @(posedge clock);
        reset_pin_n <= 1'b1;
        do @(posedge clock); while (mode_state !== PMS_ACTIVE);
    endtask : pin_reset

    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            test_done();
        end
    end

    initial begin
        {rst, reset_pin_n, avs_read, avs_write, sleep_cmd, irq_cmd} = 6'h30;
        {interrupt_mask_bit, direct_irq_enable, avs_address, avs_writedata, lag} = 0;
        void'($urandom(32'h7d9c));
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        bus(0, PMS_OFS_CTRL1, 0);
        cmp_val(rd, {24'h0, PMS_CTRL1_RST});
        bus(1, PMS_OFS_CTRL1, 32'hFF);
        bus(0, PMS_OFS_CTRL1, 0);
        cmp_val(rd, 32'hF0);
        bus(1, 4'h2, 32'hFF);
        bus(0, 4'h2, 0);
        cmp_val(rd, 0);
        for (int i = 0; i < 32; i++) begin
            dt = i[0];
            sb = i[1];
            sm = i[2];
            ls = i[3];
            if (dt != 0 && sm != 0 && ls == 0) continue;
            {ma, sa, opt, sts} = 11'($urandom);
            bus(1, PMS_OFS_CTRL1, {sb[0], sts, 4'h0});
            bus(1, PMS_OFS_CTRL2, {sm[0], ls[0], dt[0], ma, sa});
            bus(1, PMS_OFS_PERIPH, opt);
            direct_irq_enable <= !i[4];
            lag <= 2'($urandom);
            sleep_cmd <= 1'b1;
            @(posedge clock);
            sleep_cmd <= 1'b0;
            do @(negedge clock); while (sleep_exec !== 1'b1);
            @(negedge clock);
            es = (dt && !i[4]) ? (ls ? PMS_SUBACTIVE : PMS_ACTIVE)
                 : (sb && !dt) ? PMS_STANDBY : (sm ? PMS_SUBSLEEP : PMS_SLEEP);
            cmp_state(mode_state, es);
            cmp_val(sys_osc_enable, es inside {PMS_ACTIVE, PMS_SLEEP});
            cmp_val(gpio_float, es == PMS_STANDBY);
            cmp_val(cpu_run, es inside {PMS_ACTIVE, PMS_SUBACTIVE});
            if (sm != 0) cmp_val(periph_unit_reset, 1);
            if (es == PMS_SUBACTIVE) cmp_val(clock_divide, sa[1] ? 1 : 3 - sa);
            if (es inside {PMS_ACTIVE, PMS_SLEEP}) cmp_val(clock_divide, ma[2] ? ma - 1 : 0);
            if (es == PMS_SUBACTIVE) cmp_val({capture_on_sub, periph_reg_access}, {opt[2], 1'b1});
            if (es == PMS_SUBSLEEP) cmp_val(timebase_run, opt[1]);
            if (es inside {PMS_SUBACTIVE, PMS_SUBSLEEP, PMS_STANDBY}) cmp_val(watchdog_run, opt[0]);
            cmp_val(clock_from_sub, es inside {PMS_SUBACTIVE, PMS_SUBSLEEP});
            cmp_val(irq_handling_start, dt && !i[4]);
            @(posedge clock);
            if (es inside {PMS_SLEEP, PMS_SUBSLEEP} || (es == PMS_STANDBY && !i[4])) begin
                interrupt_mask_bit <= 1'b1;
                irq_cmd <= 1'b1;
                @(posedge clock);
                irq_cmd <= 1'b0;
                repeat (6) @(posedge clock);
                cmp_state(mode_state, es);
                interrupt_mask_bit <= 1'b0;
                do @(negedge clock); while (!(mode_state inside {PMS_ACTIVE, PMS_SUBACTIVE}));
                cmp_state(mode_state, (ls && es != PMS_STANDBY) ? PMS_SUBACTIVE : PMS_ACTIVE);
                cmp_val(irq_handling_start, 1);
                @(posedge clock);
            end
            pin_reset();
        end
        test_done();
    end
endmodule : test_power_mode_sequencer
